// *** design/ismc_cfg.svh ***
// offsets, field positions, reset values and timing counts of the i2c master
`ifndef ISMC_CFG_SVH
`define ISMC_CFG_SVH
`define ISMC_IDX_RX 16'hf2a0
`define ISMC_IDX_ADDR 16'hf2a1
`define ISMC_IDX_TX 16'hf2a2
`define ISMC_IDX_CON 16'hf2a3
`define ISMC_IDX_MODE 16'hf2a4
`define ISMC_IDX_STAT 16'hf2a5
`define ISMC_RST_BYTE 8'h00
`define ISMC_CON_START 0
`define ISMC_CON_STOP 1
`define ISMC_CON_RESTART 2
`define ISMC_CON_ACK 7
`define ISMC_LAST_BIT 4'h8
`define ISMC_RESP_OKAY 2'h0
`define ISMC_RESP_SLVERR 2'h2
`define ISMC_STD_LOW0 8'h2c
`define ISMC_STD_LOW1 8'h30
`define ISMC_STD_LOW2 8'h34
`define ISMC_STD_LOW3 8'h38
`define ISMC_STD_HIGH0 8'h24
`define ISMC_STD_HIGH1 8'h28
`define ISMC_STD_HIGH2 8'h2c
`define ISMC_STD_HIGH3 8'h30
`define ISMC_FAST_LOW0 8'h0c
`define ISMC_FAST_LOW1 8'h0e
`define ISMC_FAST_LOW2 8'h0e
`define ISMC_FAST_LOW3 8'h10
`define ISMC_FAST_HIGH0 8'h08
`define ISMC_FAST_HIGH1 8'h08
`define ISMC_FAST_HIGH2 8'h0a
`define ISMC_FAST_HIGH3 8'h0a
`define ISMC_STD_HOLD 8'h08
`define ISMC_FAST_HOLD 8'h04
`endif

// *** design/ismc_pkg.sv ***
// types shared by the i2c master files
package ismc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_WAIT,
    ST_RS_LOW, ST_RS_HIGH, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_BUF
  } ismc_state_type;
  typedef enum logic [1:0] {PH_ADDR, PH_TX, PH_RX} ismc_phase_type;
  typedef struct packed {
    logic clock_sync_select;
    logic [1:0] slowdown;
    logic speed_select;
    logic iface_enable;
  } ismc_mode_type;
  typedef struct packed {
    logic transmit_mismatch;
    logic ack_received;
    logic bus_busy_flag;
  } ismc_status_type;
  typedef struct packed {
    logic [7:0] low_len;
    logic [7:0] high_len;
    logic [7:0] hold_len;
  } ismc_timing_type;
endpackage

// *** design/ismc_sync.sv ***
// two-flop synchroniser, one per input bit
module ismc_sync #(
  parameter int unsigned W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge aclk)
    begin
      // idle bus level is high, so reset to released
      if (!aresetn)
      begin
        meta[i] <= 1'b1;
        q[i] <= 1'b1;
      end
      else
      begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule

// *** design/ismc_timing.sv ***
// source-clock tick and per-speed bit phase lengths
`include "ismc_cfg.svh"
module ismc_timing #(
  parameter int unsigned F_DIV = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic speed_select,
  input wire logic [1:0] slowdown,
  output logic f_tick,
  output ismc_pkg::ismc_timing_type tim
);
  logic [7:0] div_cnt;

  // one tick per source-clock period; all bus timing counts these ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn || div_cnt == 8'(F_DIV - 1))
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      f_tick <= 1'b0;
    else
      f_tick <= (div_cnt == 8'(F_DIV - 1));
  end

  // bit cycle is low phase plus high phase; slowdown lengthens the bit, and both phases at standard speed
  always_comb
  begin
    tim.hold_len = speed_select ? `ISMC_FAST_HOLD : `ISMC_STD_HOLD;
    unique case ({speed_select, slowdown})
      3'h0: begin tim.low_len = `ISMC_STD_LOW0; tim.high_len = `ISMC_STD_HIGH0; end
      3'h1: begin tim.low_len = `ISMC_STD_LOW1; tim.high_len = `ISMC_STD_HIGH1; end
      3'h2: begin tim.low_len = `ISMC_STD_LOW2; tim.high_len = `ISMC_STD_HIGH2; end
      3'h3: begin tim.low_len = `ISMC_STD_LOW3; tim.high_len = `ISMC_STD_HIGH3; end
      3'h4: begin tim.low_len = `ISMC_FAST_LOW0; tim.high_len = `ISMC_FAST_HIGH0; end
      3'h5: begin tim.low_len = `ISMC_FAST_LOW1; tim.high_len = `ISMC_FAST_HIGH1; end
      3'h6: begin tim.low_len = `ISMC_FAST_LOW2; tim.high_len = `ISMC_FAST_HIGH2; end
      3'h7: begin tim.low_len = `ISMC_FAST_LOW3; tim.high_len = `ISMC_FAST_HIGH3; end
    endcase
  end
endmodule

// *** design/ismc_top.sv ***
// single-master i2c controller with an axi4-lite register port
//
// Our own choice: the AXI4-Lite interface to the registers.
`include "ismc_cfg.svh"
// Behaviour
// - speed select 0 gives standard speed, 1 gives fast speed
// - single master only: no arbitration, no clock stretching support
// - start write 1 while idle begins; writing 0 aborts at once
// - start bit accepts 1 only while the interface is enabled
// - stop request makes a stop condition, clears start, reads 0
// - restart with start set re-sends the address; reads 0
// - start write 1 in the wait state resumes with the next byte
// - after each received byte the ack-to-send bit is driven as ack
// - enable 0 holds registers other than mode initialised; enable 1 allows operation
// - slowdown field lengthens the bit by 0, 10, 20 or 30 percent
// - sda shifts into the receive shift register at the end of every scl high phase of a byte's data bits
// - receive register updates after each byte, resets to zero
// - target address holds 7-bit address above the direction bit
// - busy set by start, cleared by stop or disable
// - ack received latched after each byte, cleared while disabled
// - mismatch set when sent bit differs; driving continues to byte end
// - mismatch cleared by a control write unless a mismatch sets in that cycle, or while disabled
// - 7-bit addressing; 10-bit done by software sending extra bytes
// - timing counted in source clock periods per speed table
// - entering the wait state raises the interrupt and pauses
// - address and transmit bytes go msb first, then ack bit
// - interrupt raised after the stop waveform completes
module ismc_top #(
  parameter int unsigned F_DIV = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  output logic bus_irq
);
  ismc_pkg::ismc_state_type state;
  ismc_pkg::ismc_phase_type phase;
  ismc_pkg::ismc_mode_type mode;
  ismc_pkg::ismc_status_type status;
  ismc_pkg::ismc_timing_type tim;
  logic [1:0] pins_s;
  logic sda_s;
  logic scl_s;
  logic sda_prev;
  logic f_tick;
  logic en;
  logic [7:0] target_address;
  logic [7:0] transmit_byte;
  logic [7:0] receive_byte;
  logic [7:0] shifter;
  logic [7:0] rx_shift;
  logic [7:0] phase_cnt;
  logic [7:0] phase_len;
  logic [3:0] bit_idx;
  logic comm_start;
  logic ack_to_send;
  logic aw_full;
  logic w_full;
  logic [15:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane;
  logic wr_fire;
  logic con_wr;
  logic start_go;
  logic resume_go;
  logic stop_go;
  logic restart_go;
  logic abort;
  logic phase_last;
  logic at_hold;
  logic drive_bit;
  logic sending;
  logic sample;
  logic mismatch_set;
  logic [7:0] rd_val;
  logic rd_hit;
  logic next_aw_full;
  logic next_w_full;
  logic next_rvalid;

  ismc_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );

  ismc_timing #(.F_DIV(F_DIV)) u_timing (
    .aclk(aclk),
    .aresetn(aresetn),
    .speed_select(mode.speed_select),
    .slowdown(mode.slowdown),
    .f_tick(f_tick),
    .tim(tim)
  );

  assign sda_s = pins_s[0];
  assign scl_s = pins_s[1];
  assign en = mode.iface_enable;

  // control-register decode
  assign wr_fire = aw_full & w_full & ~s_axi_bvalid;
  assign con_wr = wr_fire & w_lane & (aw_idx == `ISMC_IDX_CON);
  assign start_go = con_wr & w_byte[`ISMC_CON_START] & ~w_byte[`ISMC_CON_STOP] & en
    & (state == ismc_pkg::ST_IDLE) & ~status.bus_busy_flag;
  assign resume_go = con_wr & w_byte[`ISMC_CON_START] & ~w_byte[`ISMC_CON_STOP]
    & ~w_byte[`ISMC_CON_RESTART] & en & (state == ismc_pkg::ST_WAIT);
  assign stop_go = con_wr & w_byte[`ISMC_CON_STOP] & (state == ismc_pkg::ST_WAIT);
  assign restart_go = con_wr & w_byte[`ISMC_CON_RESTART] & w_byte[`ISMC_CON_START]
    & comm_start & (state == ismc_pkg::ST_WAIT);
  assign abort = con_wr & ~w_byte[`ISMC_CON_START] & ~stop_go
    & (state != ismc_pkg::ST_IDLE);

  // bit timing in source-clock ticks
  assign phase_len = (state inside {ismc_pkg::ST_START, ismc_pkg::ST_HIGH,
    ismc_pkg::ST_RS_HIGH, ismc_pkg::ST_STOP_HIGH}) ? tim.high_len : tim.low_len;
  assign phase_last = f_tick & (phase_cnt == phase_len - 8'h01);
  assign at_hold = f_tick & (phase_cnt == tim.hold_len - 8'h01);
  assign sample = (state == ismc_pkg::ST_HIGH) & phase_last;

  // released bits read as 1; receive data bits are released, its ack is driven
  always_comb
  begin
    if (bit_idx == `ISMC_LAST_BIT)
      drive_bit = (phase == ismc_pkg::PH_RX) ? ack_to_send : 1'b1;
    else
      drive_bit = (phase == ismc_pkg::PH_RX) ? 1'b1 : shifter[7];
    sending = (bit_idx == `ISMC_LAST_BIT) == (phase == ismc_pkg::PH_RX);
  end
  assign mismatch_set = sample & sending & (sda_s != drive_bit);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || phase_last || state inside {ismc_pkg::ST_IDLE, ismc_pkg::ST_WAIT})
      phase_cnt <= 8'h00;
    else if (f_tick)
      phase_cnt <= phase_cnt + 8'h01;
  end

  // sequencer; no arbitration and scl is never sampled for stretching
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en || abort)
    begin
      state <= ismc_pkg::ST_IDLE;
      phase <= ismc_pkg::PH_ADDR;
      bit_idx <= 4'h0;
      shifter <= `ISMC_RST_BYTE;
    end
    else
      unique case (state)
        ismc_pkg::ST_IDLE:
          if (start_go)
          begin
            state <= ismc_pkg::ST_START;
            phase <= ismc_pkg::PH_ADDR;
            bit_idx <= 4'h0;
            shifter <= target_address;
          end
        ismc_pkg::ST_START:
          if (phase_last)
            state <= ismc_pkg::ST_LOW;
        ismc_pkg::ST_LOW:
          if (phase_last)
            state <= ismc_pkg::ST_HIGH;
        ismc_pkg::ST_HIGH:
          if (phase_last)
          begin
            if (bit_idx == `ISMC_LAST_BIT)
              state <= ismc_pkg::ST_WAIT;
            else
            begin
              bit_idx <= bit_idx + 4'h1;
              shifter <= {shifter[6:0], 1'b1};
              state <= ismc_pkg::ST_LOW;
            end
          end
        ismc_pkg::ST_WAIT:
          if (restart_go)
            state <= ismc_pkg::ST_RS_LOW;
          else if (stop_go)
            state <= ismc_pkg::ST_STOP_LOW;
          else if (resume_go)
          begin
            state <= ismc_pkg::ST_LOW;
            bit_idx <= 4'h0;
            phase <= target_address[0] ? ismc_pkg::PH_RX : ismc_pkg::PH_TX;
            shifter <= target_address[0] ? 8'hff : transmit_byte;
          end
        ismc_pkg::ST_RS_LOW:
          if (phase_last)
            state <= ismc_pkg::ST_RS_HIGH;
        ismc_pkg::ST_RS_HIGH:
          if (phase_last)
          begin
            state <= ismc_pkg::ST_START;
            phase <= ismc_pkg::PH_ADDR;
            bit_idx <= 4'h0;
            shifter <= target_address;
          end
        ismc_pkg::ST_STOP_LOW:
          if (phase_last)
            state <= ismc_pkg::ST_STOP_HIGH;
        ismc_pkg::ST_STOP_HIGH:
          if (phase_last)
            state <= ismc_pkg::ST_STOP_BUF;
        ismc_pkg::ST_STOP_BUF:
          if (phase_last)
            state <= ismc_pkg::ST_IDLE;
      endcase
  end

  // open-drain pins: the output value is always low, only the enable moves
  always_ff @(posedge aclk)
  begin
    sda_o <= 1'b0;
    scl_o <= 1'b0;
    if (!aresetn || !en || abort)
    begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end
    else
    begin
      if (start_go || (state == ismc_pkg::ST_RS_HIGH && phase_last))
        sda_oe <= 1'b1;
      if (state == ismc_pkg::ST_LOW && at_hold)
        sda_oe <= ~drive_bit;
      if (state == ismc_pkg::ST_RS_LOW && at_hold)
        sda_oe <= 1'b0;
      if (state == ismc_pkg::ST_STOP_LOW && at_hold)
        sda_oe <= 1'b1;
      if (state == ismc_pkg::ST_STOP_HIGH && phase_last)
        sda_oe <= 1'b0;
      if (phase_last && (state inside {ismc_pkg::ST_START, ismc_pkg::ST_HIGH}))
        scl_oe <= 1'b1;
      if (phase_last && (state inside {ismc_pkg::ST_LOW, ismc_pkg::ST_RS_LOW,
          ismc_pkg::ST_STOP_LOW}))
        scl_oe <= 1'b0;
    end
  end

  // byte capture, ack, mismatch and interrupt pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en)
    begin
      rx_shift <= `ISMC_RST_BYTE;
      receive_byte <= `ISMC_RST_BYTE;
      status.ack_received <= 1'b0;
      status.transmit_mismatch <= 1'b0;
      bus_irq <= 1'b0;
    end
    else
    begin
      if (sample && bit_idx != `ISMC_LAST_BIT)
        rx_shift <= {rx_shift[6:0], sda_s};
      if (sample && bit_idx == `ISMC_LAST_BIT)
      begin
        receive_byte <= rx_shift;
        status.ack_received <= sda_s;
      end
      // a mismatch in the same cycle as a control write still sets
      if (mismatch_set)
        status.transmit_mismatch <= 1'b1;
      else if (con_wr)
        status.transmit_mismatch <= 1'b0;
      bus_irq <= (sample && bit_idx == `ISMC_LAST_BIT)
        || (state == ismc_pkg::ST_STOP_BUF && phase_last);
    end
  end

  // busy follows start and stop seen on the bus, by any party
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sda_prev <= 1'b1;
    else
      sda_prev <= sda_s;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en)
      status.bus_busy_flag <= 1'b0;
    else if (scl_s && sda_prev && !sda_s)
      status.bus_busy_flag <= 1'b1;
    else if (scl_s && !sda_prev && sda_s)
      status.bus_busy_flag <= 1'b0;
  end

  // software registers; mode survives disable so enable can be set again
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode <= '0;
    else if (wr_fire && w_lane && aw_idx == `ISMC_IDX_MODE)
      mode <= w_byte[4:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en)
    begin
      target_address <= `ISMC_RST_BYTE;
      transmit_byte <= `ISMC_RST_BYTE;
      ack_to_send <= 1'b0;
      comm_start <= 1'b0;
    end
    else
    begin
      if (wr_fire && w_lane && aw_idx == `ISMC_IDX_ADDR)
        target_address <= w_byte;
      if (wr_fire && w_lane && aw_idx == `ISMC_IDX_TX)
        transmit_byte <= w_byte;
      if (con_wr)
      begin
        ack_to_send <= w_byte[`ISMC_CON_ACK];
        comm_start <= w_byte[`ISMC_CON_START] & ~w_byte[`ISMC_CON_STOP]
          & (start_go | (state != ismc_pkg::ST_IDLE));
      end
      else if (state == ismc_pkg::ST_IDLE)
        comm_start <= 1'b0;
    end
  end

  // axi4-lite write: address and data taken in either order, then one response
  assign next_aw_full = wr_fire ? 1'b0 : (aw_full | (s_axi_awvalid & s_axi_awready));
  assign next_w_full = wr_fire ? 1'b0 : (w_full | (s_axi_wvalid & s_axi_wready));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 16'h0000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ISMC_RESP_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready <= ~next_w_full;
      if (s_axi_awvalid && s_axi_awready)
        aw_idx <= s_axi_awaddr[17:2];
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_idx >= `ISMC_IDX_RX && aw_idx <= `ISMC_IDX_STAT)
          ? `ISMC_RESP_OKAY : `ISMC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read mux; write-only control bits read as zero
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[17:2])
      `ISMC_IDX_RX: rd_val = receive_byte;
      `ISMC_IDX_ADDR: rd_val = target_address;
      `ISMC_IDX_TX: rd_val = transmit_byte;
      `ISMC_IDX_CON: rd_val = {ack_to_send, 6'h00, comm_start};
      `ISMC_IDX_MODE: rd_val = {3'h0, mode};
      `ISMC_IDX_STAT: rd_val = {5'h00, status};
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | (s_axi_arvalid & s_axi_arready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ISMC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_hit ? `ISMC_RESP_OKAY : `ISMC_RESP_SLVERR;
      end
    end
  end

  sequence s_enter_wait;
    (state != ismc_pkg::ST_WAIT) ##1 (state == ismc_pkg::ST_WAIT);
  endsequence

  sequence s_stop_done;
    (state == ismc_pkg::ST_STOP_BUF) ##1 (state == ismc_pkg::ST_IDLE);
  endsequence

  start_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (con_wr && !en) |=> !comm_start && state == ismc_pkg::ST_IDLE)
    else $error("start accepted while disabled");
  abort_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    abort |=> state == ismc_pkg::ST_IDLE && !sda_oe && !scl_oe ##1 !sda_oe)
    else $error("abort did not release the bus");
  stop_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_go |=> !comm_start && state == ismc_pkg::ST_STOP_LOW)
    else $error("stop request mishandled");
  restart_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    restart_go |=> state == ismc_pkg::ST_RS_LOW && shifter == $past(shifter))
    else $error("restart not taken");
  wait_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_enter_wait |-> bus_irq && scl_oe)
    else $error("wait entered without interrupt");
  stop_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stop_done |-> bus_irq && !sda_oe && !scl_oe)
    else $error("stop finished without interrupt");
  disable_init_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !en |=> status == '0 && receive_byte == 8'h00 && state == ismc_pkg::ST_IDLE)
    else $error("disabled block not initialised");
  mismatch_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mismatch_set && en) |=> status.transmit_mismatch)
    else $error("mismatch not flagged");
  resume_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
    resume_go |=> state == ismc_pkg::ST_LOW && bit_idx == 4'h0 && phase != ismc_pkg::PH_ADDR)
    else $error("resume did not start the next byte");
  open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) ##1 1'b1 |-> !sda_o && !scl_o)
    else $error("pin driven high");
endmodule

// *** sim/ismc_slave.sv ***
// behavioural i2c slave: acks every address byte, returns one byte on read
module ismc_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] dat,
  output logic oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic adr = 1'b0;
  logic rd = 1'b0;
  initial oe = 1'b0;
  always @(negedge sda)
    if (scl)
    begin
      cnt = 0;
      adr = 1'b1;
      rd = 1'b0;
      oe = 1'b0;
    end
  always @(posedge scl)
  begin
    cnt = cnt + 1;
    if (cnt == 8 && adr)
      rd = sda;
    // a master nack ends the read so the line is free for stop
    if (cnt == 9 && !adr && sda)
      rd = 1'b0;
  end
  always @(negedge scl)
  begin
    if (cnt == 9)
    begin
      cnt = 0;
      adr = 1'b0;
    end
    oe = (cnt == 8) ? (adr | !rd) : (rd & !adr & !dat[7 - cnt]);
  end
endmodule

// *** sim/ismc_top_test.sv ***
// self-checking bench of the i2c master behind axi4-lite
module ismc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] RX = 18'h3ca80;
  localparam logic [17:0] SA = 18'h3ca84;
  localparam logic [17:0] TX = 18'h3ca88;
  localparam logic [17:0] CON = 18'h3ca8c;
  localparam logic [17:0] MD = 18'h3ca90;
  localparam logic [17:0] ST = 18'h3ca94;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h0;
  logic [17:0] s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv;
  logic sda_oe, scl_oe, bus_irq, s_oe, spd;
  logic sda_jam = 1'b0;
  logic scl_q = 1'b1;
  logic [1:0] slw;
  logic [6:0] a;
  logic [7:0] tx;
  logic [7:0] sdat = 8'h00;
  int fail_count = 0, checks_done = 0, cyc = 0, last = 0, per = 0;
  // pull-ups: a released line reads high
  wire logic sda = !(sda_oe | s_oe | sda_jam);
  wire logic scl = !scl_oe;
  always #5 aclk = ~aclk;
  // one source tick per aclk keeps each byte under a thousand cycles
  ismc_top #(.F_DIV(1)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sda_i(sda), .sda_o(), .sda_oe, .scl_i(scl), .scl_o(), .scl_oe, .bus_irq);
  ismc_slave u_slave (.scl(scl), .sda(sda), .dat(sdat), .oe(s_oe));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bit period between scl rises; limit is several times the whole run
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    scl_q <= scl;
    if (scl && !scl_q)
    begin
      per <= cyc - last;
      last <= cyc;
    end
    if (cyc == 30000)
    begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [17:0] ad, input logic [7:0] d);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rc(input string n, input logic [17:0] ad, input logic [31:0] e);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    chk(n, e, rv);
  endtask
  task automatic wait_irq();
    do
      @(posedge aclk);
    while (bus_irq !== 1'b1);
  endtask
  function automatic int exp_per(input logic s, input logic [1:0] w);
    return s ? 20 + 2 * w : 80 + 8 * w;
  endfunction
  initial
  begin
    void'($urandom(96352));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++)
      rc("reset value", RX + 18'(4 * i), 32'h0);
    rc("unmapped read", ST + 18'h4, 32'h0);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    wr(ST, 8'hff);
    rc("status read only", ST, 32'h0);
    wr(CON, 8'h01);
    rc("start while off", CON, 32'h0);
    $display("test registers done");
    {spd, slw, a, tx, sdat} = 26'($urandom);
    wr(MD, {3'h0, 1'b0, slw, spd, 1'b1});
    wr(SA, {a, 1'b0});
    wr(CON, 8'h01);
    wait_irq();
    chk("bit period", exp_per(spd, slw), per);
    rc("address echo", RX, {24'h0, a, 1'b0});
    rc("status after address", ST, 32'h1);
    wr(TX, tx);
    wr(CON, 8'h01);
    wait_irq();
    rc("sent byte echo", RX, {24'h0, tx});
    $display("test write done");
    wr(SA, {a, 1'b1});
    wr(CON, 8'h05);
    wait_irq();
    rc("restart address", RX, {24'h0, a, 1'b1});
    rc("restart reads zero", CON, 32'h1);
    wr(CON, 8'h81);
    wait_irq();
    rc("received byte", RX, {24'h0, sdat});
    rc("ack seen", ST, 32'h3);
    wr(CON, 8'h82);
    wait_irq();
    // the nack of the read byte stays latched across the stop
    rc("status after stop", ST, 32'h2);
    rc("stop reads zero", CON, 32'h80);
    $display("test read done");
    wr(SA, 8'hff);
    wr(CON, 8'h01);
    // a stuck-low sda turns every sent 1 into a mismatch; 170 cycles stay inside byte one
    sda_jam <= 1'b1;
    repeat (170) @(posedge aclk);
    rc("mismatch flagged", ST, 32'h7);
    wr(CON, 8'h00);
    @(posedge aclk);
    chk("abort releases", 32'h0, {30'h0, sda_oe, scl_oe});
    rc("abort clears start", CON, 32'h0);
    sda_jam <= 1'b0;
    wr(MD, 8'h00);
    rc("disabled status", ST, 32'h0);
    rc("disabled receive", RX, 32'h0);
    $display("test abort done");
    summarize();
  end
endmodule
